/* File: logic/src_pkg.sv */
// Purpose: Shared constants and types for the standby and reset controller
// Assumes: APB register access, one 10 MHz clock
// Notes: Offsets are byte addresses of 32-bit words
package src_pkg;
  localparam logic [7:0] SRC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SRC_OFF_STATE = 8'h04;
  localparam logic [7:0] SRC_OFF_IRQ_REQ = 8'h08;
  localparam logic [7:0] SRC_OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] SRC_OFF_CLKSEL = 8'h10;
  localparam logic [7:0] SRC_OFF_VECTOR = 8'h14;
  localparam logic [7:0] SRC_OFF_STATUS = 8'h18;
  localparam logic [7:0] SRC_OFF_MASK = 8'h1C;
  localparam logic [7:0] SRC_OFF_REGS = 8'h20;
  localparam logic [7:0] SRC_OFF_RETAIN = 8'h24;
  // Interrupt source bit positions
  localparam int SRC_IRQ_FIRST = 0;
  localparam int SRC_IRQ_SECOND = 1;
  localparam int SRC_IRQ_THIRD = 2;
  localparam int SRC_IRQ_FIFTH = 3;
  localparam int SRC_IRQ_NUM = 8;
  // Control register fields
  localparam int SRC_CTL_STOP = 0;
  localparam int SRC_CTL_HALT = 1;
  localparam int SRC_CTL_MAIN_HALT = 2;
  // Clock select fields
  localparam int SRC_CS_SUB = 0;
  localparam int SRC_CS_SIO_EXT = 1;
  localparam int SRC_CS_TMR_EXT = 2;
  localparam int SRC_CS_WT_SUB = 3;
  localparam int SRC_CS_W = 4;
  // Status events
  localparam int SRC_EV_STOP = 0;
  localparam int SRC_EV_HALT = 1;
  localparam int SRC_EV_WAKE = 2;
  localparam int SRC_EV_W = 3;
  // Reset image
  localparam int SRC_PC_W = 14;
  localparam int SRC_BANK_EN_BIT = 7;
  localparam logic [7:0] SRC_MODULO_RST = 8'hFF;
  localparam logic [8:0] SRC_RAM_UNDEF_LO = 9'h0F8;
  localparam logic [8:0] SRC_RAM_UNDEF_HI = 9'h0FD;
  localparam logic [1:0] SRC_ROM_SMALL = 2'h0;
  localparam logic [1:0] SRC_ROM_MID = 2'h1;
  typedef enum logic [2:0] {
    SRC_RUN = 3'b001,
    SRC_HALT = 3'b010,
    SRC_STOP = 3'b100
  } src_state_t;
  typedef struct packed {
    logic sio_run;
    logic tmr_run;
    logic watch_run;
    logic lcd_run;
    logic main_osc_on;
    logic sub_osc_on;
    logic cpu_clk_on;
  } src_gate_t;
endpackage

/* File: logic/src_apb_slave.sv */
// Purpose: APB slave front end with two-cycle access phase
// Assumes: APB3 master, 32-bit data
// Notes: Produces a single-cycle write strobe
`timescale 1ns/1ps
module src_apb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] rdata_in,
  input wire logic rd_err_in,
  output logic wr_stb,
  output logic [7:0] addr,
  output logic pready_q,
  output logic pslverr_q,
  output logic [31:0] prdata_q
);
  // Access answered on the second access cycle so data is registered
  wire access = psel && penable && !pready_q;
  // Writes land on the edge that completes the transfer, never before the master sees pready
  assign wr_stb = psel && penable && pready_q && pwrite && ce;
  assign addr = paddr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      pready_q <= access;
      pslverr_q <= access && rd_err_in;
      prdata_q <= (access && !pwrite) ? rdata_in : 32'h0;
    end
  end
endmodule // src_apb_slave

/* File: logic/src_standby_ctrl.sv */
// Purpose: Standby mode control and reset state loader
// Assumes: CPU events arrive as one-cycle pulses, program words on ports
// Notes: Retained storage sampled on reset release, not under reset
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Stop instruction on main clock or clock select write on subclock enters STOP
// - Halt instruction enters HALT unless a stop is taken in the same cycle
// - STOP halts only main oscillator
// - HALT gates only the CPU clock
// - Serial runs in STOP only on external clock
// - Timer runs in STOP only on pin
// - Watch timer runs in STOP only on subclock
// - Display refreshes in STOP only if watch subclocked
// - First external interrupt ignored in standby
// - Reset or enabled interrupt ends standby
// - Program counter loaded from words 0000H/0001H
// - Bank enable flag from word bit 7
// - Skip and status flags cleared, carry kept
// - Standby reset keeps RAM and registers
// - RAM 0F8H-0FDH undefined after any reset
// - Mode registers cleared, modulo set FFH
// - Irq flags, enables, timer output cleared
// - Open-drain pins high or float, others input
// - Bias pin low with ladder, else floating
module src_standby_ctrl #(
  parameter logic [1:0] ROM_SIZE = 2'h2,
  parameter bit PULLUP_FITTED = 1'b1,
  parameter bit LADDER_FITTED = 1'b1
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  // APB
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // CPU events and program words
  input wire logic STOP_INSTR_IN,
  input wire logic HALT_INSTR_IN,
  input wire logic [7:0] PROG_WORD0_IN,
  input wire logic [7:0] PROG_WORD1_IN,
  input wire logic [src_pkg::SRC_IRQ_NUM-1:0] IRQ_EVENT_IN,
  // Clock gates and state
  output src_pkg::src_gate_t GATE_OUT,
  output logic [src_pkg::SRC_PC_W-1:0] PC_OUT,
  output logic BANK_ENABLE_OUT,
  output logic RETAIN_OUT,
  output logic [8:0] RAM_UNDEF_LO_OUT,
  output logic [8:0] RAM_UNDEF_HI_OUT,
  // Pins
  output logic [7:0] OD_PORT_OUT,
  output logic [7:0] OD_PORT_OE_OUT,
  output logic [23:0] PORT_OE_OUT,
  output logic BIAS_OUT,
  output logic BIAS_OE_OUT,
  output logic IRQ_OUT
);
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  src_pkg::src_state_t state_q, state_d;
  logic [src_pkg::SRC_IRQ_NUM-1:0] irq_req_q, irq_en_q;
  logic [src_pkg::SRC_CS_W-1:0] clksel_q;
  logic [2:0] ctrl_q;
  logic [src_pkg::SRC_EV_W-1:0] status_q, mask_q;
  logic master_en_q, main_halt_q, retain_q, loaded_q;
  logic standby_seen_q = 1'b0;
  logic [7:0] modulo_q;
  logic [3:0] skip_q;
  logic timer_oe_q, timer_ff_q;
  logic [31:0] rdata;
  logic rd_err;
  logic wr_stb;
  logic [7:0] addr;

  src_apb_slave u_apb (
    .clk(REF_CLK_IN),
    .rst_n(rst_n),
    .ce(CLK_EN_IN),
    .psel(PSEL_IN),
    .penable(PENABLE_IN),
    .pwrite(PWRITE_IN),
    .paddr(PADDR_IN),
    .rdata_in(rdata),
    .rd_err_in(rd_err),
    .wr_stb(wr_stb),
    .addr(addr),
    .pready_q(PREADY_OUT),
    .pslverr_q(PSLVERR_OUT),
    .prdata_q(PRDATA_OUT)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_ctrl = wr_stb && hit(addr, src_pkg::SRC_OFF_CTRL);
  wire wr_req = wr_stb && hit(addr, src_pkg::SRC_OFF_IRQ_REQ);
  wire wr_en = wr_stb && hit(addr, src_pkg::SRC_OFF_IRQ_EN);
  wire wr_cs = wr_stb && hit(addr, src_pkg::SRC_OFF_CLKSEL);
  wire wr_st = wr_stb && hit(addr, src_pkg::SRC_OFF_STATUS);
  wire wr_mk = wr_stb && hit(addr, src_pkg::SRC_OFF_MASK);
  wire wr_regs = wr_stb && hit(addr, src_pkg::SRC_OFF_REGS);
  wire on_sub = clksel_q[src_pkg::SRC_CS_SUB];
  wire in_run = (state_q == src_pkg::SRC_RUN);
  // Software stop request is a control register write with the stop bit set
  wire stop_sw = wr_ctrl && PWDATA_IN[src_pkg::SRC_CTL_STOP];
  wire halt_sw = wr_ctrl && PWDATA_IN[src_pkg::SRC_CTL_HALT];
  wire go_stop = in_run && (((STOP_INSTR_IN || stop_sw) && !on_sub) || (wr_cs && on_sub));
  wire go_halt = in_run && !go_stop && (HALT_INSTR_IN || halt_sw);
  // The first external input never wakes: it is stripped before the wake term
  wire [src_pkg::SRC_IRQ_NUM-1:0] wake_src = irq_req_q & irq_en_q & ~8'h01;
  wire wake = !in_run && (|wake_src);
  wire [src_pkg::SRC_IRQ_NUM-1:0] irq_gated = in_run ? IRQ_EVENT_IN : (IRQ_EVENT_IN & ~8'h01);
  wire [src_pkg::SRC_EV_W-1:0] ev = {wake, go_halt, go_stop};

  always_comb begin
    state_d = state_q;
    case (state_q)
      src_pkg::SRC_RUN: begin
        if (go_stop) begin
          state_d = src_pkg::SRC_STOP;
        end else if (go_halt) begin
          state_d = src_pkg::SRC_HALT;
        end
      end
      src_pkg::SRC_HALT, src_pkg::SRC_STOP: begin
        if (wake) begin
          state_d = src_pkg::SRC_RUN;
        end
      end
      default: state_d = src_pkg::SRC_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= src_pkg::SRC_RUN;
      irq_req_q <= '0;
      irq_en_q <= '0;
      master_en_q <= 1'b0;
      timer_oe_q <= 1'b0;
      timer_ff_q <= 1'b0;
      clksel_q <= '0;
      ctrl_q <= '0;
      modulo_q <= src_pkg::SRC_MODULO_RST;
      skip_q <= '0;
      status_q <= '0;
      mask_q <= '0;
    end else if (CLK_EN_IN) begin
      state_q <= state_d;
      irq_req_q <= (wr_req ? (irq_req_q & ~PWDATA_IN[7:0]) : irq_req_q) | irq_gated;
      if (wr_en) irq_en_q <= PWDATA_IN[7:0];
      if (wr_en) master_en_q <= PWDATA_IN[8];
      if (wr_cs) clksel_q <= PWDATA_IN[src_pkg::SRC_CS_W-1:0];
      if (wr_ctrl) ctrl_q <= PWDATA_IN[2:0];
      if (wr_regs) modulo_q <= PWDATA_IN[7:0];
      if (wr_regs) timer_oe_q <= PWDATA_IN[8];
      if (wr_regs) timer_ff_q <= PWDATA_IN[9];
      if (wr_regs) skip_q <= PWDATA_IN[15:12];
      // Set wins over a simultaneous write-one clear
      status_q <= (wr_st ? (status_q & ~PWDATA_IN[src_pkg::SRC_EV_W-1:0]) : status_q) | ev;
      if (wr_mk) mask_q <= PWDATA_IN[src_pkg::SRC_EV_W-1:0];
    end
  end

  // Standby marker has no reset so a reset taken in standby is still seen after it;
  // it powers up clear, so the first reset counts as one taken in operation
  always_ff @(posedge REF_CLK_IN) begin
    if (CLK_EN_IN && rst_n) begin
      standby_seen_q <= (state_q != src_pkg::SRC_RUN);
    end
  end

  // Retain decision and reset image taken after release, never under reset
  wire [5:0] pc_hi = (ROM_SIZE == src_pkg::SRC_ROM_SMALL) ? {2'h0, PROG_WORD0_IN[3:0]} :
                     (ROM_SIZE == src_pkg::SRC_ROM_MID) ? {1'b0, PROG_WORD0_IN[4:0]} : PROG_WORD0_IN[5:0];
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      loaded_q <= 1'b0;
      retain_q <= 1'b0;
      PC_OUT <= '0;
      BANK_ENABLE_OUT <= 1'b0;
      main_halt_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (rst_n && !loaded_q) begin
        loaded_q <= 1'b1;
        PC_OUT <= {pc_hi, PROG_WORD1_IN};
        BANK_ENABLE_OUT <= PROG_WORD0_IN[src_pkg::SRC_BANK_EN_BIT];
        retain_q <= standby_seen_q;
      end
      main_halt_q <= ctrl_q[src_pkg::SRC_CTL_MAIN_HALT];
    end
  end

  wire is_stop = (state_q == src_pkg::SRC_STOP);
  wire is_halt = (state_q == src_pkg::SRC_HALT);
  wire sub_sel = clksel_q[src_pkg::SRC_CS_WT_SUB];
  wire [src_pkg::SRC_EV_W-1:0] pend = status_q & mask_q;
  src_pkg::src_gate_t gate_d;
  always_comb begin
    gate_d.main_osc_on = !is_stop && !main_halt_q;
    gate_d.sub_osc_on = 1'b1;
    gate_d.cpu_clk_on = in_run;
    gate_d.sio_run = !is_stop || clksel_q[src_pkg::SRC_CS_SIO_EXT];
    gate_d.tmr_run = !is_stop || clksel_q[src_pkg::SRC_CS_TMR_EXT];
    gate_d.watch_run = !is_stop || sub_sel;
    gate_d.lcd_run = !is_stop || sub_sel;
  end

  assign rdata = hit(addr, src_pkg::SRC_OFF_CTRL) ? {29'h0, ctrl_q} :
                 hit(addr, src_pkg::SRC_OFF_STATE) ? {29'h0, is_stop, is_halt, in_run} :
                 hit(addr, src_pkg::SRC_OFF_IRQ_REQ) ? {24'h0, irq_req_q} :
                 hit(addr, src_pkg::SRC_OFF_IRQ_EN) ? {23'h0, master_en_q, irq_en_q} :
                 hit(addr, src_pkg::SRC_OFF_CLKSEL) ? {28'h0, clksel_q} :
                 hit(addr, src_pkg::SRC_OFF_VECTOR) ? {16'h0, BANK_ENABLE_OUT, 1'b0, PC_OUT[13:0]} :
                 hit(addr, src_pkg::SRC_OFF_STATUS) ? {29'h0, status_q} :
                 hit(addr, src_pkg::SRC_OFF_MASK) ? {29'h0, mask_q} :
                 hit(addr, src_pkg::SRC_OFF_REGS) ? {16'h0, skip_q, 2'h0, timer_ff_q, timer_oe_q, modulo_q} :
                 hit(addr, src_pkg::SRC_OFF_RETAIN) ? {31'h0, retain_q} : 32'h0;
  assign rd_err = !(hit(addr, src_pkg::SRC_OFF_CTRL) || hit(addr, src_pkg::SRC_OFF_STATE) ||
                    hit(addr, src_pkg::SRC_OFF_IRQ_REQ) || hit(addr, src_pkg::SRC_OFF_IRQ_EN) ||
                    hit(addr, src_pkg::SRC_OFF_CLKSEL) || hit(addr, src_pkg::SRC_OFF_VECTOR) ||
                    hit(addr, src_pkg::SRC_OFF_STATUS) || hit(addr, src_pkg::SRC_OFF_MASK) ||
                    hit(addr, src_pkg::SRC_OFF_REGS) || hit(addr, src_pkg::SRC_OFF_RETAIN));

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      GATE_OUT <= '0;
      RETAIN_OUT <= 1'b0;
      RAM_UNDEF_LO_OUT <= '0;
      RAM_UNDEF_HI_OUT <= '0;
      OD_PORT_OUT <= '0;
      OD_PORT_OE_OUT <= '0;
      PORT_OE_OUT <= '0;
      BIAS_OUT <= 1'b0;
      BIAS_OE_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      GATE_OUT <= gate_d;
      RETAIN_OUT <= retain_q;
      RAM_UNDEF_LO_OUT <= src_pkg::SRC_RAM_UNDEF_LO;
      RAM_UNDEF_HI_OUT <= src_pkg::SRC_RAM_UNDEF_HI;
      OD_PORT_OUT <= {8{PULLUP_FITTED}};
      OD_PORT_OE_OUT <= {8{PULLUP_FITTED}};
      BIAS_OUT <= 1'b0;
      BIAS_OE_OUT <= LADDER_FITTED;
      IRQ_OUT <= |pend;
    end
  end

  a_stop_entry: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && go_stop) |=> (state_q == src_pkg::SRC_STOP))
    else $error("stop entry missed");
  a_halt_entry: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && in_run && HALT_INSTR_IN && !go_stop) |=> is_halt)
    else $error("halt entry missed");
  a_stop_gates: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && is_stop) |=> (!GATE_OUT.main_osc_on && GATE_OUT.sub_osc_on))
    else $error("stop oscillator gating wrong");
  a_halt_cpu: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && is_halt && !main_halt_q) |=> (!GATE_OUT.cpu_clk_on && GATE_OUT.main_osc_on))
    else $error("halt gating wrong");
  a_sio_stop: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && is_stop && !clksel_q[src_pkg::SRC_CS_SIO_EXT]) |=> !GATE_OUT.sio_run)
    else $error("serial runs in stop");
  a_lcd_stop: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && is_stop) |=> (GATE_OUT.lcd_run == $past(sub_sel)))
    else $error("display gating wrong");
  a_first_ignored: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && !in_run && IRQ_EVENT_IN[src_pkg::SRC_IRQ_FIRST] && !irq_req_q[src_pkg::SRC_IRQ_FIRST]) |=>
    !irq_req_q[src_pkg::SRC_IRQ_FIRST])
    else $error("first input taken in standby");
  a_wake_exit: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (CLK_EN_IN && wake) |=> (in_run && status_q[src_pkg::SRC_EV_WAKE]))
    else $error("wake not taken");
endmodule // src_standby_ctrl

/* File: testbench/standby_and_reset_control_bench.sv */
// Purpose: Self-checking bench for the standby and reset controller
// Assumes: APB reads and writes through one shared task, CPU events as one-cycle pulses
// Notes: Default ROM size and pin options; program words give bank 1 and PC 2BCD
`timescale 1ns/1ps
module standby_and_reset_control_bench;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_i;
  logic halt_i;
  logic [src_pkg::SRC_IRQ_NUM-1:0] irq_ev;
  src_pkg::src_gate_t gate;
  logic [src_pkg::SRC_PC_W-1:0] pc;
  logic bank_en;
  logic retain;
  logic [8:0] undef_lo;
  logic [8:0] undef_hi;
  logic [7:0] od_port;
  logic [7:0] od_oe;
  logic [23:0] port_oe;
  logic bias;
  logic bias_oe;
  logic irq;
  int mismatches;
  int cmp_count;
  logic [31:0] rd;
  logic err;

  src_standby_ctrl u_dut (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .STOP_INSTR_IN(stop_i), .HALT_INSTR_IN(halt_i), .PROG_WORD0_IN(8'hAB), .PROG_WORD1_IN(8'hCD),
    .IRQ_EVENT_IN(irq_ev), .GATE_OUT(gate), .PC_OUT(pc), .BANK_ENABLE_OUT(bank_en), .RETAIN_OUT(retain),
    .RAM_UNDEF_LO_OUT(undef_lo), .RAM_UNDEF_HI_OUT(undef_hi), .OD_PORT_OUT(od_port),
    .OD_PORT_OE_OUT(od_oe), .PORT_OE_OUT(port_oe), .BIAS_OUT(bias), .BIAS_OE_OUT(bias_oe), .IRQ_OUT(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task end_of_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Request held until the rising edge that samples pready high; data taken at that edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, err}, 32'h0);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task ev(input logic s, input logic h, input logic [7:0] q);
    @(posedge clk);
    stop_i <= s;
    halt_i <= h;
    irq_ev <= q;
    @(posedge clk);
    stop_i <= 1'b0;
    halt_i <= 1'b0;
    irq_ev <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  // Mask and status land on the completing edge; the level output follows one edge later
  task ichk(input logic e);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task gchk(input logic [6:0] e);
    @(negedge clk);
    chk({25'h0, gate}, {25'h0, e});
  endtask

  // Reset values other than control, status and mask are rechecked after both kinds of reset
  task reset_state(input logic [31:0] ret);
    rdc(src_pkg::SRC_OFF_REGS, 32'h0000_00FF);
    rdc(src_pkg::SRC_OFF_IRQ_EN, 32'h0);
    rdc(src_pkg::SRC_OFF_IRQ_REQ, 32'h0);
    rdc(src_pkg::SRC_OFF_CLKSEL, 32'h0);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    rdc(src_pkg::SRC_OFF_VECTOR, 32'h0000_ABCD);
    rdc(src_pkg::SRC_OFF_RETAIN, ret);
    chk({31'h0, retain}, ret);
    chk({16'h0, bank_en, 1'b0, pc}, 32'h0000_ABCD);
    chk({14'h0, undef_lo, undef_hi}, {14'h0, 9'h0F8, 9'h0FD});
    chk({od_port, od_oe, 16'h0}, 32'hFFFF_0000);
    chk({8'h0, port_oe}, 32'h0);
    chk({30'h0, bias, bias_oe}, 32'h1);
  endtask

  task do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    mismatches = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stop_i = 1'b0;
    halt_i = 1'b0;
    irq_ev = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    reset_state(32'h0);
    gchk(7'h7F);
    // Unmapped place: read zero with error, write refused
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h40, 32'h1234_5678);
    chk({31'h0, err}, 32'h1);
    // HALT, then wake only by an enabled source other than the first
    wr(src_pkg::SRC_OFF_MASK, 32'h7);
    wr(src_pkg::SRC_OFF_IRQ_EN, 32'h1);
    ev(1'b0, 1'b1, 8'h00);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_HALT});
    gchk(7'h7E);
    ichk(1'b1);
    wr(src_pkg::SRC_OFF_MASK, 32'h0);
    ichk(1'b0);
    wr(src_pkg::SRC_OFF_MASK, 32'h7);
    ev(1'b0, 1'b0, 8'h05);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_HALT});
    wr(src_pkg::SRC_OFF_IRQ_EN, 32'h2);
    ev(1'b0, 1'b0, 8'h02);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    gchk(7'h7F);
    rdc(src_pkg::SRC_OFF_STATUS, 32'h6);
    wr(src_pkg::SRC_OFF_STATUS, 32'h7);
    rdc(src_pkg::SRC_OFF_STATUS, 32'h0);
    ichk(1'b0);
    rdc(src_pkg::SRC_OFF_IRQ_REQ, 32'h6);
    wr(src_pkg::SRC_OFF_IRQ_REQ, 32'hFF);
    rdc(src_pkg::SRC_OFF_IRQ_REQ, 32'h0);
    // HALT requested by software through the control register
    wr(src_pkg::SRC_OFF_CTRL, 32'h2);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_HALT});
    ev(1'b0, 1'b0, 8'h02);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    wr(src_pkg::SRC_OFF_IRQ_REQ, 32'hFF);
    // STOP on the main clock with every peripheral on internal clocks
    ev(1'b1, 1'b0, 8'h00);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_STOP});
    gchk(7'h02);
    wr(src_pkg::SRC_OFF_IRQ_EN, 32'h4);
    ev(1'b0, 1'b0, 8'h04);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    // A pending enabled request would end the next standby at once
    wr(src_pkg::SRC_OFF_IRQ_REQ, 32'hFF);
    // STOP with external serial clock, event pin and watch on the subsystem clock
    wr(src_pkg::SRC_OFF_CLKSEL, 32'hE);
    ev(1'b1, 1'b0, 8'h00);
    gchk(7'h7A);
    wr(src_pkg::SRC_OFF_IRQ_EN, 32'h8);
    ev(1'b0, 1'b0, 8'h08);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    wr(src_pkg::SRC_OFF_IRQ_REQ, 32'hFF);
    // Clock select write enters STOP only once the subsystem clock runs the chip
    wr(src_pkg::SRC_OFF_CLKSEL, 32'hF);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    wr(src_pkg::SRC_OFF_CLKSEL, 32'hF);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_STOP});
    gchk(7'h7A);
    ev(1'b0, 1'b0, 8'h08);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_RUN});
    wr(src_pkg::SRC_OFF_IRQ_REQ, 32'hFF);
    ev(1'b0, 1'b1, 8'h00);
    rdc(src_pkg::SRC_OFF_STATE, {29'h0, src_pkg::SRC_HALT});
    gchk(7'h7E);
    // Reset while in standby: retention flagged, mode state cleared again
    do_reset();
    reset_state(32'h1);
    gchk(7'h7F);
    end_of_test();
  end
endmodule // standby_and_reset_control_bench
